// File: logic/host_mailbox_semaphore_port.sv
// mailbox, lock and control registers shared by cpu and slave-bus master
// assumes: cpu port on clk, master byte port from the bus engine on link_clk
`include "mbx_port_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module host_mailbox_semaphore_port
  import mbx_port_pkg::*;
(
  // clocks and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    link_clk,
  // cpu register port
  input  wire logic                    cpu_rd,
  input  wire logic                    cpu_wr,
  input  wire logic [`MBX_ADDR_W-1:0]  cpu_addr,
  input  wire logic [7:0]              cpu_wdata,
  output logic                         cpu_ready,
  output logic [7:0]                   cpu_rdata,
  // master byte port from the bus engine, link_clk domain
  input  wire logic                    m_req,
  input  wire logic                    m_wr,
  input  wire logic [`MBX_ADDR_W-1:0]  m_addr,
  input  wire logic [7:0]              m_wdata,
  output logic                         m_ready,
  output logic                         m_done,
  output logic [7:0]                   m_rdata,
  // pins and system status
  input  wire logic                    spi_select_n,
  input  wire logic                    i2c_awake,
  input  wire logic                    stop_mode,
  // port control towards the bus engines and cpu
  output logic                         i2c_enable,
  output logic                         spi_enable,
  output logic [6:0]                   slave_addr,
  output logic                         port_irq,
  output logic                         cpu_wake,
  output logic                         lock_timeout_irq
);

  // register state
  logic [7:0]           mailbox_byte [`MBX_COUNT];
  lock_owner_t          lock_owner_field [2];
  logic [7:0]           slave_bus_address;
  logic                 port_en;
  logic                 port_select;
  logic                 stop_irq_en;
  wake_sel_t            wake_mailbox_select;
  logic                 write_irq_en;
  logic [31:0]          master_write_flags;
  logic [31:0]          master_read_flags;
  logic                 irq_pending;
  logic                 tmo_en   [2];
  logic [3:0]           tmo_exp  [2];
  logic                 tmo_sts  [2];
  logic                 tmo_run  [2];
  logic [`TMO_CNT_W-1:0] tmo_cnt [2];

  // pin synchronisers and boot capture
  logic                 ssel_s1, ssel_s2;
  logic                 awake_s1, awake_s2;
  logic [1:0]           boot_cnt;
  logic                 booted;
  logic                 port_active;

  always_ff @(posedge clk) begin
    ssel_s1  <= spi_select_n;
    ssel_s2  <= ssel_s1;
    awake_s1 <= i2c_awake;
    awake_s2 <= awake_s1;
  end

  // wait for the synchroniser to settle before sampling the strap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boot_cnt <= 2'h0;
      booted   <= 1'b0;
    end else if (!booted) begin
      boot_cnt <= boot_cnt + 2'h1;
      booted   <= (boot_cnt == `BOOT_WAIT);
    end
  end

  assign port_active = port_select ? ~ssel_s2 : awake_s2;

  // link side: capture request, toggle across, wait for ack toggle
  logic                   lrst_s1, lrst_s2;
  link_state_t            link_state;
  logic                   req_tog;
  logic                   l_wr;
  logic [`MBX_ADDR_W-1:0] l_addr;
  logic [7:0]             l_wdata;
  logic                   ack_s1, ack_s2, ack_seen;
  logic                   ack_tog;
  logic [7:0]             m_rdata_sys;

  always_ff @(posedge link_clk) begin
    lrst_s1 <= sys_rst;
    lrst_s2 <= lrst_s1;
    ack_s1  <= ack_tog;
    ack_s2  <= ack_s1;
  end

  always_ff @(posedge link_clk) begin
    if (lrst_s2) begin
      link_state <= LINK_IDLE;
      req_tog    <= 1'b0;
      ack_seen   <= 1'b0;
      l_wr       <= 1'b0;
      l_addr     <= 6'h00;
      l_wdata    <= 8'h00;
      m_done     <= 1'b0;
      m_rdata    <= 8'h00;
    end else begin
      m_done <= 1'b0;
      case (link_state)
        LINK_IDLE: begin
          if (m_req) begin
            l_wr       <= m_wr;
            l_addr     <= m_addr;
            l_wdata    <= m_wdata;
            req_tog    <= ~req_tog;
            link_state <= LINK_BUSY;
          end
        end
        LINK_BUSY: begin
          // sys side holds m_rdata_sys steady until the next request
          if (ack_s2 != ack_seen) begin
            ack_seen   <= ack_s2;
            m_rdata    <= m_rdata_sys;
            m_done     <= 1'b1;
            link_state <= LINK_IDLE;
          end
        end
        default: link_state <= LINK_IDLE;
      endcase
    end
  end

  assign m_ready = (link_state == LINK_IDLE) && !lrst_s2;

  // system side of the master handshake
  logic req_s1, req_s2, req_seen;
  logic m_go;

  always_ff @(posedge clk) begin
    req_s1 <= req_tog;
    req_s2 <= req_s1;
  end

  assign m_go = (req_s2 != req_seen);

  // decoded accesses
  logic m_act, m_mbx_wr, m_mbx_rd, c_mbx, c_wr_ok;
  logic [4:0] m_idx;
  logic       m_claim [2];
  logic       c_claim [2];
  logic       lock_wr [2];

  assign m_act    = m_go && port_en;
  assign m_idx    = l_addr[4:0];
  assign m_mbx_wr = m_act && l_wr && (l_addr <= `OFS_MAILBOX_LAST);
  assign m_mbx_rd = m_act && !l_wr && (l_addr <= `OFS_MAILBOX_LAST);
  assign c_mbx    = (cpu_addr <= `OFS_MAILBOX_LAST);
  // hold cpu mailbox write while master writes a mailbox
  assign cpu_ready = !(cpu_wr && c_mbx && m_mbx_wr);
  assign c_wr_ok   = cpu_wr && cpu_ready;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lock
      localparam logic [5:0] LOFS = `OFS_LOCK0 + 6'(g);
      // master claim first, cpu only if master did not
      assign m_claim[g] = m_act && !l_wr && (l_addr == LOFS)
                          && (lock_owner_field[g] == LOCK_FREE);
      assign c_claim[g] = cpu_rd && (cpu_addr == LOFS) && !m_claim[g]
                          && (lock_owner_field[g] == LOCK_FREE);
      assign lock_wr[g] = (m_act && l_wr && (l_addr == LOFS))
                          || (c_wr_ok && (cpu_addr == LOFS));
    end
  endgenerate

  // register read view shared by both sides
  function automatic logic [7:0] read_view(
    input logic [`MBX_ADDR_W-1:0] a
  );
    logic [7:0] v;
    logic [1:0] k;
    v = 8'h00;
    k = a[1:0];
    if (a <= `OFS_MAILBOX_LAST) begin
      v = mailbox_byte[a[4:0]];
    end else if (a == `OFS_LOCK0 || a == `OFS_LOCK1) begin
      v = {6'h00, lock_owner_field[a[0]]};
    end else if (a == `OFS_SLAVE_ADDR) begin
      // reserved while spi is in use
      v = port_select ? 8'h00 : {1'b0, slave_bus_address[6:0]};
    end else if (a == `OFS_CTRL) begin
      v = {port_en, port_select, port_active, 1'b0, stop_irq_en,
           wake_mailbox_select, write_irq_en};
    end else if (a >= `OFS_WFLAGS0 && a <= `OFS_WFLAGS3) begin
      // first flag register holds mailboxes 31..24
      v = master_write_flags[8*(3-k) +: 8];
    end else if (a >= `OFS_RFLAGS0 && a <= `OFS_RFLAGS3) begin
      v = master_read_flags[8*(3-k) +: 8];
    end else if (a == `OFS_TIMEOUT0 || a == `OFS_TIMEOUT1) begin
      // low address bit picks the lock: 0x2C is lock 0, 0x2D is lock 1
      v = {tmo_sts[a[0]], tmo_en[a[0]], 2'h0, tmo_exp[a[0]]};
    end
    return v;
  endfunction

  // both read paths look at the same state in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      // the losing reader sees the host claim
      if (cpu_addr == `OFS_LOCK0 && m_claim[0]) begin
        cpu_rdata <= {6'h00, LOCK_HOST};
      end else if (cpu_addr == `OFS_LOCK1 && m_claim[1]) begin
        cpu_rdata <= {6'h00, LOCK_HOST};
      end else begin
        cpu_rdata <= read_view(cpu_addr);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_seen    <= 1'b0;
      ack_tog     <= 1'b0;
      m_rdata_sys <= 8'h00;
    end else if (m_go) begin
      req_seen    <= req_s2;
      ack_tog     <= ~ack_tog;
      // disabled port answers reads with zero
      m_rdata_sys <= port_en ? read_view(l_addr) : 8'h00;
    end
  end

  // mailbox storage, held cpu write lands after master write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `MBX_COUNT; i++) begin
        mailbox_byte[i] <= 8'h00;
      end
    end else begin
      if (c_wr_ok && c_mbx) begin
        mailbox_byte[cpu_addr[4:0]] <= cpu_wdata;
      end
      if (m_mbx_wr) begin
        mailbox_byte[m_idx] <= l_wdata;
      end
    end
  end

  // locks: claim wins over a same-cycle release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_owner_field[0] <= LOCK_FREE;
      lock_owner_field[1] <= LOCK_FREE;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (m_claim[i]) begin
          lock_owner_field[i] <= LOCK_HOST;
        end else if (c_claim[i]) begin
          lock_owner_field[i] <= LOCK_CPU;
        end else if (lock_wr[i]) begin
          lock_owner_field[i] <= LOCK_FREE;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 2; i++) begin
        tmo_run[i] <= 1'b0;
        tmo_sts[i] <= 1'b0;
        tmo_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (m_claim[i] || c_claim[i]) begin
          tmo_cnt[i] <= `TMO_BASE_CYCLES << tmo_exp[i];
          tmo_run[i] <= tmo_en[i];
        end else if (lock_wr[i]) begin
          tmo_run[i] <= 1'b0;
          tmo_sts[i] <= 1'b0;
        end else if (tmo_run[i]) begin
          tmo_cnt[i] <= tmo_cnt[i] - `TMO_CNT_W'(1);
          if (tmo_cnt[i] == `TMO_CNT_W'(1)) begin
            tmo_sts[i] <= 1'b1;
            tmo_run[i] <= 1'b0;
          end
        end
      end
    end
  end

  assign lock_timeout_irq = tmo_sts[0] | tmo_sts[1];

  // configuration writes; master write wins over cpu in one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slave_bus_address   <= `SLAVE_ADDR_RESET;
      port_en             <= `CTRL_EN_RESET;
      stop_irq_en         <= 1'b0;
      wake_mailbox_select <= WAKE_NONE;
      write_irq_en        <= 1'b0;
      tmo_en[0]           <= 1'b0;
      tmo_en[1]           <= 1'b0;
      tmo_exp[0]          <= 4'h0;
      tmo_exp[1]          <= 4'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        logic                   w;
        logic [`MBX_ADDR_W-1:0] a;
        logic [7:0]             d;
        w = (s == 0) ? c_wr_ok : (m_act && l_wr);
        a = (s == 0) ? cpu_addr : l_addr;
        d = (s == 0) ? cpu_wdata : l_wdata;
        if (w && a == `OFS_SLAVE_ADDR && !port_select) begin
          slave_bus_address <= {1'b0, d[6:0]};
        end
        if (w && a == `OFS_CTRL) begin
          port_en             <= d[`CTRL_EN];
          stop_irq_en         <= d[`CTRL_STOP_EN];
          wake_mailbox_select <= wake_sel_t'(d[`CTRL_WAKE_HI:`CTRL_WAKE_LO]);
          write_irq_en        <= d[`CTRL_WIE];
        end
        if (w && (a == `OFS_TIMEOUT0 || a == `OFS_TIMEOUT1)) begin
          tmo_en[a[0]]  <= d[`TMO_EN];
          tmo_exp[a[0]] <= d[`TMO_MTE_HI:0];
        end
      end
    end
  end

  // port select from strap once synchronised, then software
  logic ctrl_wr;
  logic [7:0] ctrl_d;
  assign ctrl_wr = (m_act && l_wr && l_addr == `OFS_CTRL)
                   || (c_wr_ok && cpu_addr == `OFS_CTRL);
  assign ctrl_d  = (m_act && l_wr && l_addr == `OFS_CTRL) ? l_wdata
                                                          : cpu_wdata;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_select <= 1'b0;
    end else if (!booted) begin
      port_select <= ~ssel_s2;
    end else if (ctrl_wr) begin
      port_select <= ctrl_d[`CTRL_PS];
    end
  end

  assign i2c_enable = port_en && !port_select;
  assign spi_enable = port_en && port_select;
  assign slave_addr = slave_bus_address[6:0];

  logic flag_clr;
  assign flag_clr = ctrl_wr && ctrl_d[`CTRL_CSR];

  // per-mailbox flags; set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      master_write_flags <= 32'h0000_0000;
      master_read_flags  <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < `MBX_COUNT; i++) begin
        if (m_mbx_wr && m_idx == 5'(i)) begin
          master_write_flags[i] <= 1'b1;
        end else if (flag_clr) begin
          master_write_flags[i] <= 1'b0;
        end
        if (m_mbx_rd && m_idx == 5'(i)) begin
          master_read_flags[i] <= 1'b1;
        end else if (flag_clr) begin
          master_read_flags[i] <= 1'b0;
        end
      end
    end
  end

  logic wake_hit;
  always_comb begin
    case (wake_mailbox_select)
      WAKE_ANY:  wake_hit = m_mbx_wr;
      WAKE_MB15: wake_hit = m_mbx_wr && (m_idx == `WAKE_MB15_IDX);
      WAKE_MB31: wake_hit = m_mbx_wr && (m_idx == `WAKE_MB31_IDX);
      default:   wake_hit = 1'b0;
    endcase
  end

  // pending write interrupt, cleared by the flag-clear strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_pending <= 1'b0;
      cpu_wake    <= 1'b0;
    end else begin
      if (wake_hit && write_irq_en) begin
        irq_pending <= 1'b1;
      end else if (flag_clr) begin
        irq_pending <= 1'b0;
      end
      cpu_wake <= wake_hit && stop_mode;
    end
  end

  assign port_irq = irq_pending && (stop_irq_en || !stop_mode);

endmodule // host_mailbox_semaphore_port

`default_nettype wire

// File: logic/mbx_port_pkg.sv
// types shared by the mailbox and lock port
// assumes: constants come from mbx_port_regs.svh
package mbx_port_pkg;

  typedef enum logic [1:0] {
    LOCK_FREE = 2'h0,
    LOCK_HOST = 2'h1,
    LOCK_CPU  = 2'h2
  } lock_owner_t;

  typedef enum logic [1:0] {
    WAKE_ANY  = 2'h0,
    WAKE_MB15 = 2'h1,
    WAKE_MB31 = 2'h2,
    WAKE_NONE = 2'h3
  } wake_sel_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b01,
    LINK_BUSY = 2'b10
  } link_state_t;

endpackage

// File: logic/mbx_port_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes: byte-wide registers on a 6-bit byte address space
`ifndef MBX_PORT_REGS_SVH
`define MBX_PORT_REGS_SVH

`define MBX_ADDR_W        6
`define MBX_COUNT         32
`define OFS_MAILBOX_LAST  6'h1F
`define OFS_LOCK0         6'h20
`define OFS_LOCK1         6'h21
`define OFS_SLAVE_ADDR    6'h22
`define OFS_CTRL          6'h23
`define OFS_WFLAGS0       6'h24
`define OFS_WFLAGS3       6'h27
`define OFS_RFLAGS0       6'h28
`define OFS_RFLAGS3       6'h2B
`define OFS_TIMEOUT0      6'h2C
`define OFS_TIMEOUT1      6'h2D

`define CTRL_EN           7
`define CTRL_PS           6
`define CTRL_ACTIVE       5
`define CTRL_CSR          4
`define CTRL_STOP_EN      3
`define CTRL_WAKE_HI      2
`define CTRL_WAKE_LO      1
`define CTRL_WIE          0

`define TMO_STATUS        7
`define TMO_EN            6
`define TMO_MTE_HI        3

`define SLAVE_ADDR_RESET  8'h4C
`define CTRL_EN_RESET     1'b1
`define WAKE_MB15_IDX     5'h0F
`define WAKE_MB31_IDX     5'h1F
`define TMO_BASE_CYCLES   23'h000080
`define TMO_CNT_W         23
`define BOOT_WAIT         2'h3

`endif

// File: verif/host_engine_model.sv
// model of the slave-bus engine driving the master byte port
// assumes: link_clk runs free; bench calls xfer one at a time
`include "mbx_port_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module host_engine_model (
  // link clock
  input  wire logic                   link_clk,
  // answers from the port
  input  wire logic                   m_ready,
  input  wire logic                   m_done,
  input  wire logic [7:0]             m_rdata,
  // requests to the port
  output logic                        m_req,
  output logic                        m_wr,
  output logic [`MBX_ADDR_W-1:0]      m_addr,
  output logic [7:0]                  m_wdata
);
  // extra idle link cycles before a request, for a slow host
  int gap = 0;

  initial begin
    m_req = 1'b0;
    m_wr = 1'b0;
    m_addr = '1;
    m_wdata = '1;
  end

  task automatic xfer(input logic w, input logic [`MBX_ADDR_W-1:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic seen;
    seen = 1'b0;
    repeat (gap + 1) @(posedge link_clk);
    #1;
    m_req = 1'b1;
    m_wr = w;
    m_addr = a;
    m_wdata = d;
    while (!seen) begin
      seen = (m_ready === 1'b1);
      @(posedge link_clk);
      #1;
    end
    m_req = 1'b0;
    // released lines flip so a stale value never passes for data
    m_addr = ~a;
    m_wdata = ~d;
    for (int i = 0; i < 20 && m_done !== 1'b1; i++) begin
      @(posedge link_clk);
      #1;
    end
    q = m_rdata;
  endtask
endmodule // host_engine_model

`default_nettype wire

// File: verif/mbx_port_monitor.sv
// assertions on the pins of the mailbox and lock port
// assumes: bound into host_mailbox_semaphore_port, ports seen as they are
`include "mbx_port_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mbx_port_monitor (
  // clocks and reset
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic                   link_clk,
  // cpu port
  input wire logic                   cpu_rd,
  input wire logic                   cpu_wr,
  input wire logic [`MBX_ADDR_W-1:0] cpu_addr,
  input wire logic [7:0]             cpu_wdata,
  input wire logic                   cpu_ready,
  input wire logic [7:0]             cpu_rdata,
  // master port
  input wire logic                   m_req,
  input wire logic                   m_ready,
  input wire logic                   m_done,
  // status and control
  input wire logic                   stop_mode,
  input wire logic                   i2c_enable,
  input wire logic                   spi_enable,
  input wire logic [6:0]             slave_addr,
  input wire logic                   cpu_wake
);
  wire ctl_wr = cpu_wr && cpu_ready && cpu_addr == `OFS_CTRL;
  wire lk_rd  = cpu_rd && !cpu_wr && cpu_addr == `OFS_LOCK0;

  a_port_off_ctl: assert property (@(posedge clk) disable iff (sys_rst)
    ctl_wr && !cpu_wdata[7] |=> !i2c_enable && !spi_enable)
    else $error("port still enabled");
  a_i2c_chosen: assert property (@(posedge clk) disable iff (sys_rst)
    ctl_wr && cpu_wdata[7:6] == 2'b10 |=> i2c_enable && !spi_enable)
    else $error("i2c not chosen");
  a_spi_chosen: assert property (@(posedge clk) disable iff (sys_rst)
    ctl_wr && cpu_wdata[7:6] == 2'b11 |=> spi_enable && !i2c_enable)
    else $error("spi not chosen");
  a_lock_claimed: assert property (@(posedge clk) disable iff (sys_rst)
    lk_rd ##1 lk_rd |=> cpu_rdata[1:0] != 2'b00)
    else $error("lock free on second read");
  a_clear_reads_0: assert property (@(posedge clk) disable iff (sys_rst)
    cpu_rd && cpu_addr == `OFS_CTRL |=> !cpu_rdata[`CTRL_CSR])
    else $error("flag clear bit reads 1");
  a_addr_loaded: assert property (@(posedge clk) disable iff (sys_rst)
    cpu_wr && cpu_addr == `OFS_SLAVE_ADDR && i2c_enable
    |=> {1'b0, slave_addr} == ($past(cpu_wdata) & 8'h7F))
    else $error("slave address not loaded");
  a_ready_holdoff: assert property (@(posedge clk) disable iff (sys_rst)
    !cpu_ready |-> cpu_wr && cpu_addr <= `OFS_MAILBOX_LAST ##1 cpu_ready)
    else $error("cpu write held off wrongly");
  a_wake_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    cpu_wake |-> $past(stop_mode) ##1 !cpu_wake)
    else $error("wake outside stop or too long");
  a_take_done: assert property (@(posedge link_clk) disable iff (sys_rst)
    m_req && m_ready |=> !m_ready ##[1:10] m_done)
    else $error("master transfer not completed");
endmodule // mbx_port_monitor

bind host_mailbox_semaphore_port mbx_port_monitor mon (
  .clk, .sys_rst, .link_clk, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata,
  .cpu_ready, .cpu_rdata, .m_req, .m_ready, .m_done, .stop_mode,
  .i2c_enable, .spi_enable, .slave_addr, .cpu_wake
);

`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the mailbox and lock port
// assumes: host_engine_model plays the bus engine on link_clk
`include "mbx_port_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top import mbx_port_pkg::*;;
  typedef struct packed {
    logic                   w;
    logic [`MBX_ADDR_W-1:0] a;
    logic [7:0]             d;
  } row_t;

  logic                   clk = 0, link_clk = 0, sys_rst = 1;
  logic                   cpu_rd = 0, cpu_wr = 0, cpu_ready, m_ready;
  logic [`MBX_ADDR_W-1:0] cpu_addr = 0, m_addr;
  logic [7:0]             cpu_wdata = 0, cpu_rdata, m_rdata, m_wdata;
  logic [7:0]             q, q2;
  logic                   m_req, m_wr, m_done, port_irq, cpu_wake;
  logic                   spi_select_n = 1, i2c_awake = 0, stop_mode = 0;
  logic                   i2c_enable, spi_enable, lock_timeout_irq;
  logic [6:0]             slave_addr;
  int                     errors = 0, cmp_count = 0, wakes = 0, n;
  logic [5:0]             mbs [3] = '{6'h03, 6'h0F, 6'h1F};
  row_t                   rows [16] = '{
    '{1'b0, 6'h22, 8'h4C}, '{1'b0, 6'h23, 8'h86}, '{1'b1, 6'h05, 8'hA5},
    '{1'b0, 6'h05, 8'hA5}, '{1'b1, 6'h1F, 8'h3C}, '{1'b0, 6'h1F, 8'h3C},
    '{1'b1, 6'h22, 8'hB3}, '{1'b0, 6'h22, 8'h33}, '{1'b1, 6'h3F, 8'hFF},
    '{1'b0, 6'h3F, 8'h00}, '{1'b0, 6'h21, 8'h00}, '{1'b0, 6'h21, 8'h02},
    '{1'b1, 6'h21, 8'h5A}, '{1'b0, 6'h21, 8'h00}, '{1'b1, 6'h21, 8'h00},
    '{1'b0, 6'h24, 8'h00}};

  always #4 clk = ~clk;
  always #6 link_clk = ~link_clk;
  always @(posedge clk) if (cpu_wake === 1'b1) wakes <= wakes + 1;

  host_mailbox_semaphore_port DUT (
    .clk, .sys_rst, .link_clk, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata,
    .cpu_ready, .cpu_rdata, .m_req, .m_wr, .m_addr, .m_wdata, .m_ready,
    .m_done, .m_rdata, .spi_select_n, .i2c_awake, .stop_mode, .i2c_enable,
    .spi_enable, .slave_addr, .port_irq, .cpu_wake, .lock_timeout_irq);
  host_engine_model host (
    .link_clk, .m_ready, .m_done, .m_rdata, .m_req, .m_wr, .m_addr,
    .m_wdata);

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // all cpu tasks start and end at a falling edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    cpu_wr = 0;
    cpu_rd = 1;
    cpu_addr = a;
    @(negedge clk);
    d = cpu_rdata;
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    rd(a, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    cpu_rd = 0;
    cpu_wr = 1;
    cpu_addr = a;
    cpu_wdata = d;
    for (int i = 0; i < 8 && cpu_ready !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic idle(input int c);
    cpu_rd = 0;
    cpu_wr = 0;
    repeat (c) @(negedge clk);
  endtask
  task automatic mx(input logic w, input logic [5:0] a, input logic [7:0] d);
    idle(0);
    host.xfer(w, a, d, q2);
    @(negedge clk);
  endtask

  initial begin
    idle(6);
    sys_rst = 0;
    idle(8);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rc(rows[i].a, rows[i].d);
    end
    chk({1'b0, slave_addr}, 8'h33);
    mx(1, 6'h0F, 8'h6E);
    rc(6'h0F, 8'h6E);
    rc(6'h26, 8'h80);
    fork
      host.xfer(0, 6'h05, 8'h00, q2);
      repeat (12) rc(6'h05, 8'hA5);
    join
    chk(q2, 8'hA5);
    rc(6'h2B, 8'h20);
    wr(6'h23, 8'h96);
    rc(6'h26, 8'h00);
    rc(6'h2B, 8'h00);
    // master and cpu write different mailboxes in the same window
    n = 0;
    wr(6'h08, 8'h22);
    fork
      host.xfer(1, 6'h07, 8'h11, q2);
      repeat (40) begin
        @(negedge clk);
        n += (cpu_ready !== 1'b1);
      end
    join
    chk(8'(n), 8'h01);
    rc(6'h07, 8'h11);
    rc(6'h08, 8'h22);
    mx(0, 6'h20, 8'h00);
    chk(q2, 8'h00);
    rc(6'h20, {6'h0, LOCK_HOST});
    mx(0, 6'h20, 8'h00);
    chk(q2, {6'h0, LOCK_HOST});
    mx(1, 6'h20, 8'hC3);
    rc(6'h20, 8'h00);
    rc(6'h21, 8'h00);
    mx(0, 6'h20, 8'h00);
    chk(q2, {6'h0, LOCK_CPU});
    mx(0, 6'h21, 8'h00);
    chk(q2, {6'h0, LOCK_CPU});
    mx(1, 6'h21, 8'h00);
    wr(6'h20, 8'h00);
    // timeout 128 cycles: enabled, exponent 0
    wr(6'h2C, 8'h40);
    rc(6'h20, 8'h00);
    idle(100);
    chk({7'h0, lock_timeout_irq}, 8'h00);
    idle(60);
    chk({7'h0, lock_timeout_irq}, 8'h01);
    wr(6'h20, 8'h00);
    idle(3);
    chk({7'h0, lock_timeout_irq}, 8'h00);
    wr(6'h2C, 8'h00);
    // sweep cpu start against the master claim, exactly one winner
    for (int k = 0; k < 12; k++) begin
      n = 0;
      fork
        host.xfer(0, 6'h20, 8'h00, q2);
        begin
          idle(k);
          repeat (16) begin
            rd(6'h20, q);
            n += (q === 8'h00);
          end
        end
      join
      n += (q2 === 8'h00);
      chk(8'(n), 8'h01);
      wr(6'h20, 8'h00);
    end
    stop_mode = 1;
    host.gap = 2;
    for (int s = 0; s < 4; s++) begin
      wr(6'h23, {5'h10, 2'(s), 1'b0});
      foreach (mbs[j]) begin
        n = wakes;
        mx(1, mbs[j], 8'h00);
        chk(8'(wakes - n), 8'(s == 0 || s == 1 && mbs[j] == 6'h0F ||
            s == 2 && mbs[j] == 6'h1F));
      end
    end
    host.gap = 0;
    wr(6'h23, 8'h93);
    mx(1, 6'h0F, 8'h01);
    chk({7'h0, port_irq}, 8'h00);
    stop_mode = 0;
    idle(2);
    chk({7'h0, port_irq}, 8'h01);
    wr(6'h23, 8'h9B);
    idle(1);
    chk({7'h0, port_irq}, 8'h00);
    stop_mode = 1;
    mx(1, 6'h0F, 8'h02);
    chk({7'h0, port_irq}, 8'h01);
    stop_mode = 0;
    wr(6'h23, 8'h06);
    idle(1);
    chk({6'h0, i2c_enable, spi_enable}, 8'h00);
    mx(0, 6'h05, 8'h00);
    chk(q2, 8'h00);
    // select changes only while disabled, enable while bus idle
    wr(6'h23, 8'h46);
    wr(6'h23, 8'hC6);
    wr(6'h22, 8'h55);
    spi_select_n = 0;
    idle(4);
    chk({6'h0, i2c_enable, spi_enable}, 8'h01);
    rc(6'h23, 8'hE6);
    rc(6'h22, 8'h00);
    spi_select_n = 1;
    idle(4);
    rc(6'h23, 8'hC6);
    wr(6'h23, 8'h46);
    wr(6'h23, 8'h06);
    wr(6'h23, 8'h86);
    i2c_awake = 1;
    idle(4);
    rc(6'h23, 8'hA6);
    chk({6'h0, i2c_enable, spi_enable}, 8'h02);
    spi_select_n = 0;
    sys_rst = 1;
    idle(6);
    sys_rst = 0;
    idle(8);
    rc(6'h23, 8'hE6);
    idle(2);
    report_and_stop();
  end

  initial begin
    #200us;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
